//--- hdl/pwc_pkg.sv
// Shared types and constants of the processor bus wait controller
package pwc_pkg;

	// Wait counter figures: load values, idle and terminal counts
	localparam logic [3:0] PWC_LOAD_IO = 4'h5;
	localparam logic [3:0] PWC_LOAD_ROM = 4'h1;
	localparam logic [3:0] PWC_LOAD_RECOVER = 4'ha;
	localparam logic [3:0] PWC_TIMER_IDLE = 4'h0;
	localparam logic [3:0] PWC_TIMER_DONE = 4'hf;

	// Processor status lines of the current bus cycle
	typedef struct packed {
		logic mem_or_io;
		logic write_not_read;
		logic data_not_control;
		logic top_addr_bit;
	} pwc_status_type;

	// Decoder strobes, all active low, held in the decoder flops
	typedef struct packed {
		logic io_read_n;
		logic io_write_n;
		logic rom_read_n;
		logic int_ack_n;
		logic ready_hold_n;
		logic recovery_n;
	} pwc_strobe_type;

	// Strobe pattern of each decoder state; bit order as in the struct
	localparam pwc_strobe_type PWC_OUT_IDLE = 6'h3f;
	localparam pwc_strobe_type PWC_OUT_IORD_WAIT = 6'h1f;
	localparam pwc_strobe_type PWC_OUT_IORD_FIN = 6'h1d;
	localparam pwc_strobe_type PWC_OUT_IOWR_WAIT = 6'h2f;
	localparam pwc_strobe_type PWC_OUT_IOWR_FIN = 6'h2d;
	localparam pwc_strobe_type PWC_OUT_ROM_WAIT = 6'h37;
	localparam pwc_strobe_type PWC_OUT_ROM_FIN = 6'h35;
	localparam pwc_strobe_type PWC_OUT_INTA_WAIT = 6'h3b;
	localparam pwc_strobe_type PWC_OUT_INTA_FIN = 6'h39;
	localparam pwc_strobe_type PWC_OUT_RECOVER = 6'h3e;

	typedef enum logic [1:0] {TRK_WAIT, TRK_ACTIVE, TRK_PIPE} pwc_trk_type;
	typedef enum logic {XCVR_WAIT, XCVR_ENABLE} pwc_xcvr_type;
	typedef enum logic [3:0] {
		DEC_IDLE, DEC_IORD_WAIT, DEC_IORD_FIN, DEC_IOWR_WAIT, DEC_IOWR_FIN,
		rom_wait_state, rom_finish_state, DEC_INTA_WAIT, DEC_INTA_FIN,
		DEC_RECOVER
	} pwc_dec_type;

	// Whole state of the controller
	typedef struct packed {
		logic phase;
		pwc_trk_type trk;
		pwc_xcvr_type xcvr;
		pwc_dec_type dec;
		pwc_strobe_type strobes;
		logic [3:0] timer;
	} pwc_state_type;

	localparam pwc_state_type PWC_STATE_RESET = '{
		phase: 1'b0, trk: TRK_WAIT, xcvr: XCVR_WAIT, dec: DEC_IDLE,
		strobes: PWC_OUT_IDLE, timer: PWC_TIMER_IDLE};

endpackage

//--- hdl/pwc_bus_ctrl.sv
// Processor bus wait controller: tracker, transceiver gate, decoder, timer
`timescale 1ns/1ns

module pwc_bus_ctrl
	import pwc_pkg::*;
#(
	parameter logic [3:0] LOAD_IO = PWC_LOAD_IO,
	parameter logic [3:0] LOAD_ROM = PWC_LOAD_ROM,
	parameter logic [3:0] LOAD_RECOVER = PWC_LOAD_RECOVER
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic addr_strobe_n_in,
	input wire logic ready_n_in,
	input wire logic next_addr_n_in,
	input wire pwc_status_type status_in,
	output logic bus_phase_clk_out,
	output logic cycle_live_n_out,
	output logic pipelined_n_out,
	output logic xcvr_enable_n_out,
	output pwc_strobe_type strobes_out,
	output logic wait_done_out
);

	// A zero load would be read as idle and a load of fifteen never counts
	if (LOAD_IO == PWC_TIMER_IDLE || LOAD_IO == PWC_TIMER_DONE ||
		LOAD_ROM == PWC_TIMER_IDLE || LOAD_ROM == PWC_TIMER_DONE ||
		LOAD_RECOVER == PWC_TIMER_IDLE ||
		LOAD_RECOVER == PWC_TIMER_DONE) begin : g_load_check
		$error("pwc_bus_ctrl: wait loads must lie between 1 and 14");
	end

	pwc_state_type st;
	pwc_state_type next_st;
	logic wait_done;
	logic any_io_n;
	logic all_idle;

	// Strobe pattern that each decoder state puts on its flops
	function automatic pwc_strobe_type strobe_of(input pwc_dec_type d);
		pwc_strobe_type s;
		s = PWC_OUT_IDLE;
		unique case (d)
		DEC_IDLE: s = PWC_OUT_IDLE;
		DEC_IORD_WAIT: s = PWC_OUT_IORD_WAIT;
		DEC_IORD_FIN: s = PWC_OUT_IORD_FIN;
		DEC_IOWR_WAIT: s = PWC_OUT_IOWR_WAIT;
		DEC_IOWR_FIN: s = PWC_OUT_IOWR_FIN;
		rom_wait_state: s = PWC_OUT_ROM_WAIT;
		rom_finish_state: s = PWC_OUT_ROM_FIN;
		DEC_INTA_WAIT: s = PWC_OUT_INTA_WAIT;
		DEC_INTA_FIN: s = PWC_OUT_INTA_FIN;
		DEC_RECOVER: s = PWC_OUT_RECOVER;
		default: s = PWC_OUT_IDLE;
		endcase
		return s;
	endfunction

	// Counter terminal count and strobe summaries feeding the next state
	assign wait_done = (st.timer == PWC_TIMER_DONE);
	assign any_io_n = st.strobes.io_read_n & st.strobes.io_write_n &
		st.strobes.int_ack_n;
	assign all_idle = any_io_n & st.strobes.rom_read_n;

	// All next-state logic; reset is synchronous and overrides everything
	always_comb begin
		next_st = st;
		// Toggle keeps the phase locked to the processor clock
		next_st.phase = ~st.phase;

		// Bus cycle tracker
		unique case (st.trk)
		TRK_WAIT: begin
			if (!addr_strobe_n_in && st.phase) begin
				next_st.trk = TRK_ACTIVE;
			end
		end
		TRK_ACTIVE: begin
			if (!ready_n_in && st.phase) begin
				if (addr_strobe_n_in) begin
					next_st.trk = TRK_WAIT;
				end else begin
					next_st.trk = TRK_PIPE;
				end
			end
		end
		TRK_PIPE: begin
			if (st.phase) begin
				next_st.trk = TRK_ACTIVE;
			end
		end
		default: next_st.trk = TRK_WAIT;
		endcase

		// Transceiver gate; only non-pipelined, non-recovery cycles open it
		unique case (st.xcvr)
		XCVR_WAIT: begin
			if (next_addr_n_in && !cycle_live_n_out &&
				st.strobes.recovery_n) begin
				next_st.xcvr = XCVR_ENABLE;
			end
		end
		XCVR_ENABLE: begin
			if (cycle_live_n_out && st.phase) begin
				next_st.xcvr = XCVR_WAIT;
			end
		end
		endcase

		// Cycle decoder; each move is taken on a fast clock edge
		unique case (st.dec)
		DEC_IDLE: begin
			if (next_addr_n_in && !cycle_live_n_out && st.phase) begin
				// Status bits: high memory, read, data
				if (status_in.top_addr_bit && status_in.mem_or_io &&
					status_in.data_not_control &&
					!status_in.write_not_read) begin
					next_st.dec = rom_wait_state;
				end else if (!status_in.top_addr_bit &&
					!status_in.mem_or_io && status_in.data_not_control &&
					status_in.write_not_read) begin
					next_st.dec = DEC_IOWR_WAIT;
				end else if (!status_in.top_addr_bit &&
					!status_in.mem_or_io && status_in.data_not_control &&
					!status_in.write_not_read) begin
					next_st.dec = DEC_IORD_WAIT;
				end else if (!status_in.top_addr_bit &&
					!status_in.mem_or_io && !status_in.data_not_control &&
					!status_in.write_not_read) begin
					next_st.dec = DEC_INTA_WAIT;
				end else if (status_in.mem_or_io &&
					!status_in.data_not_control &&
					status_in.write_not_read) begin
					// Memory control write (halt) skips the wait phase
					next_st.dec = DEC_IOWR_FIN;
				end else begin
					next_st.dec = DEC_RECOVER;
				end
			end
		end
		rom_wait_state: begin
			if (wait_done) begin
				next_st.dec = rom_finish_state;
			end
		end
		rom_finish_state: begin
			if (st.phase) begin
				next_st.dec = DEC_IDLE;
			end
		end
		DEC_IOWR_WAIT: begin
			if (wait_done) begin
				next_st.dec = DEC_IOWR_FIN;
			end
		end
		DEC_IOWR_FIN: begin
			// I/O writes need recovery, memory control writes do not
			if (st.phase) begin
				if (status_in.mem_or_io) begin
					next_st.dec = DEC_IDLE;
				end else begin
					next_st.dec = DEC_RECOVER;
				end
			end
		end
		DEC_IORD_WAIT: begin
			if (wait_done) begin
				next_st.dec = DEC_IORD_FIN;
			end
		end
		DEC_IORD_FIN: begin
			if (st.phase) begin
				next_st.dec = DEC_RECOVER;
			end
		end
		DEC_INTA_WAIT: begin
			if (wait_done) begin
				next_st.dec = DEC_INTA_FIN;
			end
		end
		DEC_INTA_FIN: begin
			if (st.phase) begin
				next_st.dec = DEC_RECOVER;
			end
		end
		DEC_RECOVER: begin
			if (wait_done && st.phase) begin
				next_st.dec = DEC_IDLE;
			end
		end
		default: next_st.dec = DEC_IDLE;
		endcase
		// Outputs are the state flops themselves, no glitchy decode
		next_st.strobes = strobe_of(next_st.dec);

		// Wait counter, fed by the strobes already on the pins
		if (st.timer == PWC_TIMER_IDLE) begin
			if (!any_io_n) begin
				next_st.timer = LOAD_IO;
			end else if (!st.strobes.rom_read_n) begin
				next_st.timer = LOAD_ROM;
			end else if (!st.strobes.recovery_n) begin
				next_st.timer = LOAD_RECOVER;
			end else begin
				next_st.timer = PWC_TIMER_IDLE;
			end
		end else if (st.timer == PWC_TIMER_DONE) begin
			// Hold done until the decoder has dropped every read, write, ROM and acknowledge strobe
			if (all_idle) begin
				next_st.timer = PWC_TIMER_IDLE;
			end else begin
				next_st.timer = PWC_TIMER_DONE;
			end
		end else begin
			next_st.timer = 4'(st.timer + 4'h1);
		end

		if (!rst_n_in) begin
			next_st = PWC_STATE_RESET;
		end
	end

	// Single register bank; load and count are synchronous only
	always_ff @(posedge core_clk_in) begin
		st <= next_st;
	end

	// Outputs straight from the state flops
	assign bus_phase_clk_out = st.phase;
	assign cycle_live_n_out = (st.trk != TRK_ACTIVE);
	assign pipelined_n_out = (st.trk != TRK_PIPE);
	assign xcvr_enable_n_out = (st.xcvr != XCVR_ENABLE);
	assign strobes_out = st.strobes;
	assign wait_done_out = wait_done;

	// Checks on the controller's own behaviour
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	a_phase_toggle: assert property ($past(rst_n_in) |->
		bus_phase_clk_out != $past(bus_phase_clk_out))
		else $error("bus phase clock failed to toggle");
	a_reset_start: assert property (disable iff (1'b0)
		!rst_n_in |=> st.trk == TRK_WAIT && xcvr_enable_n_out &&
		strobes_out == PWC_OUT_IDLE && st.timer == PWC_TIMER_IDLE)
		else $error("reset did not reach the start-up state");
	a_track_start: assert property (
		st.trk == TRK_WAIT && !addr_strobe_n_in && st.phase
		|=> !cycle_live_n_out)
		else $error("tracker missed the start of a cycle");
	a_track_end: assert property (
		st.trk == TRK_ACTIVE && !ready_n_in && st.phase |=>
		($past(addr_strobe_n_in) ? st.trk == TRK_WAIT : !pipelined_n_out))
		else $error("tracker ended the cycle wrongly");
	a_pipe_back: assert property (
		!pipelined_n_out && st.phase |=> !cycle_live_n_out)
		else $error("pipelined state did not return to active");
	a_flags_exclusive: assert property (
		!pipelined_n_out |-> cycle_live_n_out ##1
		(pipelined_n_out || cycle_live_n_out))
		else $error("live and pipelined flags both low");
	a_xcvr_open: assert property (
		xcvr_enable_n_out && next_addr_n_in && !cycle_live_n_out &&
		strobes_out.recovery_n |=> !xcvr_enable_n_out)
		else $error("transceiver gate failed to open");
	a_xcvr_close: assert property (
		!xcvr_enable_n_out && cycle_live_n_out && st.phase
		|=> xcvr_enable_n_out)
		else $error("transceiver gate failed to close");
	a_rom_ready: assert property (
		st.dec == rom_wait_state && wait_done |=>
		!strobes_out.rom_read_n && !strobes_out.ready_hold_n ##[1:2]
		strobes_out == PWC_OUT_IDLE)
		else $error("ROM read did not finish with ready");
	a_load_io: assert property (
		st.timer == PWC_TIMER_IDLE && !strobes_out.io_read_n
		|=> st.timer == LOAD_IO)
		else $error("counter did not load the I/O wait");
	a_count_step: assert property (
		st.timer != PWC_TIMER_IDLE && st.timer != PWC_TIMER_DONE
		|=> st.timer == 4'($past(st.timer) + 4'h1))
		else $error("counter did not step by one");
	a_recover_hold: assert property (
		st.dec == DEC_RECOVER && !(wait_done && st.phase)
		|=> !strobes_out.recovery_n)
		else $error("recovery left without completion");
	a_no_early: assert property (
		(st.dec == DEC_IORD_WAIT || st.dec == DEC_IOWR_WAIT ||
		st.dec == DEC_INTA_WAIT || st.dec == rom_wait_state) &&
		!wait_done |=> strobes_out.ready_hold_n)
		else $error("ready released before the count finished");

	// Ready, decode, gate and counter loading and hold checks
	a_wait_exit: assert property (
		(st.dec == DEC_IORD_WAIT || st.dec == DEC_IOWR_WAIT ||
		st.dec == DEC_INTA_WAIT || st.dec == rom_wait_state) &&
		wait_done |=> !strobes_out.ready_hold_n)
		else $error("ready not given once the count finished");
	a_rom_decode: assert property (
		st.dec == DEC_IDLE && next_addr_n_in && !cycle_live_n_out &&
		st.phase && status_in.top_addr_bit && status_in.mem_or_io &&
		status_in.data_not_control && !status_in.write_not_read
		|=> !strobes_out.rom_read_n)
		else $error("ROM read was not decoded");
	a_decode_block: assert property (
		st.dec == DEC_IDLE && !next_addr_n_in |=> strobes_out == PWC_OUT_IDLE)
		else $error("decoder left idle with next address low");
	a_gate_shut: assert property (
		xcvr_enable_n_out && !(next_addr_n_in && !cycle_live_n_out &&
		strobes_out.recovery_n) |=> xcvr_enable_n_out)
		else $error("transceiver gate opened without cause");
	a_load_rom: assert property (
		st.timer == PWC_TIMER_IDLE && any_io_n && !strobes_out.rom_read_n
		|=> st.timer == LOAD_ROM)
		else $error("counter did not load the ROM wait");
	a_load_recover: assert property (
		st.timer == PWC_TIMER_IDLE && all_idle && !strobes_out.recovery_n
		|=> st.timer == LOAD_RECOVER)
		else $error("counter did not load the recovery wait");
	a_done_hold: assert property (
		wait_done && !all_idle |=> wait_done)
		else $error("counter left done while a strobe was low");

	c_rom_read: cover property (st.dec == rom_finish_state);
	c_io_write: cover property (
		st.dec == DEC_IOWR_FIN ##1 st.dec == DEC_RECOVER);
	c_int_ack: cover property (st.dec == DEC_INTA_FIN);
	c_pipelined: cover property (!pipelined_n_out);
	c_recovery: cover property (st.dec == DEC_RECOVER && wait_done && st.phase);

endmodule

//--- sim/pwc_host_model.sv
// Behavioural host processor driving bus cycles into the controller
`timescale 1ns/1ns

module pwc_host_model
	import pwc_pkg::*;
(
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic pipe_in,
	input wire logic slow_in,
	input wire logic na_in,
	input wire pwc_status_type kind_in,
	input wire logic phase_in,
	input wire logic cycle_live_n_in,
	input wire pwc_strobe_type strobes_in,
	output logic addr_strobe_n_out,
	output logic ready_n_out,
	output logic next_addr_n_out,
	output pwc_status_type status_out
);
	int n;
	int k;

	// Drive just after each edge, like the bench
	task step;
		@(posedge clk_in);
		#1;
	endtask

	initial begin
		addr_strobe_n_out = 1'b1;
		ready_n_out = 1'b1;
		next_addr_n_out = 1'b1;
		status_out = 4'h0;
	end

	// One cycle per request, two when pipe_in is set; strobe launched so a phase-high edge takes it
	always begin
		step;
		if (go_in && phase_in) begin
			status_out = kind_in;
			next_addr_n_out = na_in;
			addr_strobe_n_out = 1'b0;
			for (n = 0; n < 8 && cycle_live_n_in; n++) step;
			if (slow_in) repeat (3) step;
			addr_strobe_n_out = 1'b1;
			for (k = 0; k < (pipe_in ? 2 : 1); k++) begin
				// Gives up after a bound so a blocked decode cannot hang
				for (n = 0; n < 40 && strobes_in.ready_hold_n; n++) step;
				if (!phase_in) step;
				ready_n_out = 1'b0;
				addr_strobe_n_out = !(pipe_in && k == 0);
				step;
				ready_n_out = 1'b1;
				addr_strobe_n_out = 1'b1;
			end
			next_addr_n_out = 1'b1;
		end
	end
endmodule

//--- sim/processor_bus_wait_controller_tb.sv
// Self-checking bench for the processor bus wait controller
`timescale 1ns/1ns

module processor_bus_wait_controller_tb;
	import pwc_pkg::*;
	logic core_clk_in, rst_n_in, as_n, rdy_n, na_n, phase, live_n, pipe_n;
	logic xcvr_n, wait_done, go, pipe, slow, na;
	pwc_status_type status, kind;
	pwc_strobe_type strobes;
	int errors, checked;

	pwc_bus_ctrl pwc_bus_ctrl_inst (.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in), .addr_strobe_n_in(as_n), .ready_n_in(rdy_n),
		.next_addr_n_in(na_n), .status_in(status),
		.bus_phase_clk_out(phase), .cycle_live_n_out(live_n),
		.pipelined_n_out(pipe_n), .xcvr_enable_n_out(xcvr_n),
		.strobes_out(strobes), .wait_done_out(wait_done));

	pwc_host_model pwc_host_model_inst (.clk_in(core_clk_in), .go_in(go),
		.pipe_in(pipe), .slow_in(slow), .na_in(na), .kind_in(kind),
		.phase_in(phase), .cycle_live_n_in(live_n), .strobes_in(strobes),
		.addr_strobe_n_out(as_n), .ready_n_out(rdy_n),
		.next_addr_n_out(na_n), .status_out(status));

	// 100 MHz fast clock
	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end

	task tick;
		@(posedge core_clk_in);
		#1;
	endtask

	task conclude;
		$display("Comparisons %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task cmp_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task cmp_vec(input logic [5:0] got, input logic [5:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// A spent bound ends the run as a mismatch
	task limit(input int n, input int lim);
		if (n >= lim) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, n, 0);
			conclude;
		end
	endtask

	task wait_idle;
		int n;
		for (n = 0; n < 60 && strobes !== PWC_OUT_IDLE; n++) tick;
		limit(n, 60);
		repeat (16) tick;
	endtask

	// Full cycle: wait state, counted delay, finish, optional recovery
	task run_cycle(input pwc_status_type k, input pwc_strobe_type wt,
		input pwc_strobe_type fn, input int load, input logic rec);
		int n;
		logic seen;
		kind = k;
		go = 1'b1;
		for (n = 0; n < 20 && strobes === PWC_OUT_IDLE; n++) tick;
		limit(n, 20);
		go = 1'b0;
		cmp_vec(strobes, wt);
		cmp_bit(xcvr_n, 1'b0);
		for (n = 0; n < 20 && wait_done !== 1'b1; n++) tick;
		limit(n, 20);
		cmp_vec(6'(n), 6'(16 - load));
		cmp_vec(strobes, wt);
		tick;
		cmp_vec(strobes, fn);
		seen = 1'b0;
		for (n = 0; n < 40 && strobes !== PWC_OUT_IDLE; n++) begin
			seen |= strobes === PWC_OUT_RECOVER;
			tick;
		end
		limit(n, 40);
		cmp_bit(seen, rec);
		repeat (3) tick;
		cmp_bit(xcvr_n, 1'b1);
		cmp_bit(live_n, 1'b1);
		repeat (16) tick;
	endtask

	// Status codes that skip the wait states
	task direct(input pwc_status_type k, input pwc_strobe_type first);
		int n;
		kind = k;
		go = 1'b1;
		for (n = 0; n < 20 && strobes === PWC_OUT_IDLE; n++) tick;
		limit(n, 20);
		go = 1'b0;
		cmp_vec(strobes, first);
		// Host only readies after its own bound when no ready comes back
		for (n = 0; n < 80 && live_n !== 1'b1; n++) tick;
		limit(n, 80);
		wait_idle;
	endtask

	// Back-to-back cycle through the pipelined state
	task pipelined;
		int n;
		pipe = 1'b1;
		kind = 4'hb;
		go = 1'b1;
		for (n = 0; n < 40 && pipe_n !== 1'b0; n++) tick;
		limit(n, 40);
		go = 1'b0;
		cmp_bit(live_n, 1'b1);
		repeat (2) tick;
		cmp_bit(live_n, 1'b0);
		cmp_bit(pipe_n, 1'b1);
		for (n = 0; n < 40 && strobes !== PWC_OUT_ROM_FIN; n++) tick;
		limit(n, 40);
		wait_idle;
		pipe = 1'b0;
	endtask

	// Next-address low keeps decoder and gate out of the cycle
	task blocked;
		int n;
		logic bad;
		na = 1'b0;
		go = 1'b1;
		bad = 1'b0;
		// Hold the request until the host has really started a cycle
		for (n = 0; n < 20 && live_n !== 1'b0; n++) tick;
		limit(n, 20);
		go = 1'b0;
		repeat (30) begin
			tick;
			bad |= strobes !== PWC_OUT_IDLE || xcvr_n !== 1'b1;
		end
		cmp_bit(bad, 1'b0);
		na = 1'b1;
		repeat (30) tick;
	endtask

	// Start-up state under reset, then the free-running phase clock
	task reset_phase;
		logic p;
		repeat (12) tick;
		cmp_vec(strobes, PWC_OUT_IDLE);
		cmp_bit(phase, 1'b0);
		cmp_bit(live_n, 1'b1);
		cmp_bit(pipe_n, 1'b1);
		cmp_bit(xcvr_n, 1'b1);
		cmp_bit(wait_done, 1'b0);
		rst_n_in = 1'b1;
		tick;
		p = phase;
		repeat (4) begin
			tick;
			cmp_bit(phase, ~p);
			p = phase;
		end
	endtask

	// Reset in mid-cycle sends decoder and tracker home and clears wait done
	task mid_reset;
		int n;
		kind = 4'hb;
		go = 1'b1;
		for (n = 0; n < 20 && strobes === PWC_OUT_IDLE; n++) tick;
		limit(n, 20);
		go = 1'b0;
		rst_n_in = 1'b0;
		tick;
		rst_n_in = 1'b1;
		cmp_vec(strobes, PWC_OUT_IDLE);
		cmp_bit(live_n, 1'b1);
		cmp_bit(wait_done, 1'b0);
		repeat (50) tick;
	endtask

	initial begin
		errors = 0;
		checked = 0;
		rst_n_in = 1'b0;
		go = 1'b0;
		pipe = 1'b0;
		slow = 1'b0;
		na = 1'b1;
		kind = 4'h0;
		reset_phase;
		run_cycle(4'hb, PWC_OUT_ROM_WAIT, PWC_OUT_ROM_FIN, 1, 1'b0);
		run_cycle(4'h2, PWC_OUT_IORD_WAIT, PWC_OUT_IORD_FIN, 5, 1'b1);
		slow = 1'b1;
		run_cycle(4'h6, PWC_OUT_IOWR_WAIT, PWC_OUT_IOWR_FIN, 5, 1'b1);
		slow = 1'b0;
		run_cycle(4'h0, PWC_OUT_INTA_WAIT, PWC_OUT_INTA_FIN, 5, 1'b1);
		direct(4'hc, PWC_OUT_IOWR_FIN);
		direct(4'ha, PWC_OUT_RECOVER);
		pipelined;
		blocked;
		mid_reset;
		conclude;
	end
endmodule
